// ### shared/timer16_map.vh
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH

// Mode control register fields.
`define MODE_OVF_BIT 0
`define MODE_OP_LO 2
`define MODE_OP_HI 3
`define MODE_RESET 8'h00

// Operating modes held in the two operating-mode bits.
`define OP_STOP 2'h0
`define OP_CLEAR_EDGE 2'h1
`define OP_FREE_RUN 2'h2
`define OP_CLEAR_MATCH 2'h3

// Capture/compare control register fields.
`define CCR_A_CAPTURE 0
`define CCR_A_SRC_INV 1
`define CCR_B_CAPTURE 2
`define CCR_RESET 8'h00

// Output control register fields.
`define OUT_ENABLE 0
`define OUT_LEVEL_RESET 2
`define OUT_LEVEL_SET 3
`define OUT_ONE_SHOT 5
`define OUT_TRIGGER 6
`define OUT_RESET 8'h00
`define OUT_READ_MASK 8'hb3

// Prescaler register fields.
`define PRE_SEL_LO 0
`define PRE_SEL_HI 1
`define PRE_EDGE_A_LO 4
`define PRE_EDGE_A_HI 5
`define PRE_EDGE_B_LO 6
`define PRE_EDGE_B_HI 7
`define PRE_RESET 8'h00

// Valid-edge encodings.
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_NONE 2'h2
`define EDGE_BOTH 2'h3

// Count clock divide ratios as powers of two.
`define DIV_SHIFT_0 3'h0
`define DIV_SHIFT_1 3'h2
`define DIV_SHIFT_2 3'h4
`define DIV_SHIFT_3 3'h7

`define COUNT_RESET 16'h0000
`define COUNT_TOP 16'hffff

`endif

// ### design/pin_edge_filter.v
`timescale 1ns/1ps
`default_nettype none

module pin_edge_filter (
    // Clock and reset.
    input wire sys_clk,
    input wire reset,
    // Pin and sampling control.
    input wire pin,
    input wire sample_tick,
    input wire enable,
    // Filtered edges, one cycle each.
    output reg rise,
    output reg fall
);

    reg sync_first;
    reg sync_second;
    reg sample_prev;
    reg level;

    always @(posedge sys_clk) begin
        if (reset) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first <= pin;
            sync_second <= sync_first;
        end
    end

    // A level counts only after two equal samples at the count clock, so
    // short glitches never reach the counter.  While stopped the filtered
    // level is frozen, which makes a changed pin show as an edge at start.
    always @(posedge sys_clk) begin
        if (reset) begin
            sample_prev <= 1'b0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (enable && sample_tick) begin
                sample_prev <= sync_second;
                if (sample_prev == sync_second && level != sync_second) begin
                    level <= sync_second;
                    rise <= sync_second;
                    fall <= ~sync_second;
                end
            end
        end
    end

endmodule // pin_edge_filter

`default_nettype wire

// ### design/timer16_one_shot_pulse.v
// Operation
// [RULE1] Trigger bit clears and starts counter; output toggles at compare matches.
// [RULE2] If second compare exceeds first, roles swap; equal values not allowed. The code starts on compare b only when it is below compare a.
// [RULE3] Counter keeps counting after pulse; only mode 00 stops it.
// [RULE4] No new trigger while a pulse is still being output.
// [RULE5] External trigger edge also clears and starts in software trigger mode.
// [RULE6] Software loads both compare registers nonzero before one-shot use.
// [RULE7] Counter runs at once for mode other than 00; 00 stops.
// [RULE8] Start is asynchronous to count clock; first match may vary one tick.
// [RULE9] Reading the counter does not capture into the second register.
// [RULE10] Counting pauses during a counter read, giving a count error.
// [RULE11] While stopped, pin edges cause neither counting nor interrupts.
// [RULE12] Compare of zero matches on the 0000H to 0001H step.
// [RULE13] Compare below count: counter overflows and wraps before matching.
// [RULE14] Capture/compare contents are not guaranteed after stop.
// [RULE15] Output level set and reset bits always read zero.
// [RULE16] Trigger bit clears itself and always reads zero.
// [RULE17] Two count clocks between triggers; trigger only in one-shot mode.
// [RULE18] One-shot works only in free-running or clear-on-edge mode.
// [RULE19] Overflow flag sets on FFFFH to 0000H step in every running mode.
// [RULE20] Clearing the overflow flag before count reaches 0001H has no effect.
// [RULE21] Capture wins over a coinciding read; capture at stop is undefined.
// [RULE22] Software stops the timer before rewriting configuration registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.vh"

module timer16_one_shot_pulse #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input wire sys_clk,
    input wire reset,
    // Register writes from software.
    input wire mode_wr,
    input wire capture_ctrl_wr,
    input wire output_ctrl_wr,
    input wire prescaler_wr,
    input wire compare_a_wr,
    input wire compare_b_wr,
    input wire [7:0] reg_wdata,
    input wire [WIDTH-1:0] compare_wdata,
    // Counter read access, high for the whole access.
    input wire counter_read,
    // Timer pins.
    input wire trigger_capture_input_a,
    input wire trigger_capture_input_b,
    output reg pulse_output_pin,
    // Register contents seen by software.
    output reg [WIDTH-1:0] main_counter16,
    output reg [WIDTH-1:0] compare_reg_a,
    output reg [WIDTH-1:0] compare_reg_b,
    output reg [7:0] mode_control_reg,
    output reg [7:0] capture_compare_control_reg,
    output reg [7:0] output_control_reg,
    output reg [7:0] prescaler_reg,
    // Events, one cycle each.
    output reg match_irq_a,
    output reg match_irq_b
);

    localparam [WIDTH-1:0] COUNT_ZERO = `COUNT_RESET;
    localparam [WIDTH-1:0] COUNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam [WIDTH-1:0] COUNT_MAX = `COUNT_TOP;

    reg [6:0] divider;
    reg just_overflowed;
    reg pulse_armed;
    reg pulse_level;

    wire [1:0] op_mode;
    wire running;
    wire one_shot_mode;
    wire count_tick;
    wire sample_tick;
    wire rise_a;
    wire fall_a;
    wire rise_b;
    wire fall_b;
    wire edge_a;
    wire edge_a_inverse;
    wire edge_b;
    wire soft_trigger;
    wire edge_trigger;
    wire restart;
    wire a_is_capture;
    wire b_is_capture;
    wire capture_a;
    wire capture_b;
    wire match_a;
    wire match_b;
    wire overflow;
    wire start_on_b;
    wire start_match;
    wire stop_match;
    wire clear_ovf;

    // Decodes a filtered edge pair against a valid-edge selection.
    function edge_valid;
        input [1:0] sel;
        input r;
        input f;
        begin
            case (sel)
                `EDGE_FALL: edge_valid = f;
                `EDGE_RISE: edge_valid = r;
                `EDGE_BOTH: edge_valid = r | f;
                default: edge_valid = 1'b0;
            endcase
        end
    endfunction

    // Maps the prescaler selection to a count clock tick.
    function tick_of;
        input [1:0] sel;
        input [6:0] div;
        reg [2:0] shift;
        reg [6:0] mask;
        begin
            shift = `DIV_SHIFT_0;
            case (sel)
                2'h1: shift = `DIV_SHIFT_1;
                2'h2: shift = `DIV_SHIFT_2;
                2'h3: shift = `DIV_SHIFT_3;
                default: shift = `DIV_SHIFT_0;
            endcase
            mask = (7'h01 << shift) - 7'h01;
            tick_of = ((div & mask) == mask);
        end
    endfunction

    assign op_mode = mode_control_reg[`MODE_OP_HI:`MODE_OP_LO];
    assign running = (op_mode != `OP_STOP); // [RULE7]
    assign one_shot_mode = output_control_reg[`OUT_ONE_SHOT] &&
        (op_mode == `OP_FREE_RUN || op_mode == `OP_CLEAR_EDGE); // [RULE18]

    // The divider runs free and is never aligned to a start, so the first
    // match after start may come up to one count clock early or late.
    assign sample_tick = tick_of(prescaler_reg[`PRE_SEL_HI:`PRE_SEL_LO],
        divider); // [RULE8]
    assign count_tick = sample_tick && running && !counter_read; // [RULE10]

    // Index 0 is input a and index 1 is input b.
    wire [1:0] pin_in;
    wire [1:0] pin_rise;
    wire [1:0] pin_fall;

    assign pin_in = {trigger_capture_input_b, trigger_capture_input_a};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : pin_filters
            pin_edge_filter filter (
                .sys_clk(sys_clk),
                .reset(reset),
                .pin(pin_in[g]),
                .sample_tick(sample_tick),
                .enable(running), // [RULE11]
                .rise(pin_rise[g]),
                .fall(pin_fall[g])
            );
        end
    endgenerate

    assign rise_a = pin_rise[0];
    assign fall_a = pin_fall[0];
    assign rise_b = pin_rise[1];
    assign fall_b = pin_fall[1];

    assign edge_a = running && edge_valid(
        prescaler_reg[`PRE_EDGE_A_HI:`PRE_EDGE_A_LO], rise_a, fall_a);
    assign edge_a_inverse = running && edge_valid(
        prescaler_reg[`PRE_EDGE_A_HI:`PRE_EDGE_A_LO], fall_a, rise_a);
    assign edge_b = running && edge_valid(
        prescaler_reg[`PRE_EDGE_B_HI:`PRE_EDGE_B_LO], rise_b, fall_b);

    // The trigger bit acts only in one-shot mode and is never stored.
    assign soft_trigger = output_ctrl_wr && reg_wdata[`OUT_TRIGGER] &&
        one_shot_mode; // [RULE1] [RULE16]
    // The pin stays live as a trigger even when software triggers are used.
    assign edge_trigger = edge_a &&
        (op_mode == `OP_CLEAR_EDGE || one_shot_mode); // [RULE5]
    assign restart = running && (soft_trigger || edge_trigger);

    assign a_is_capture = capture_compare_control_reg[`CCR_A_CAPTURE];
    assign b_is_capture = capture_compare_control_reg[`CCR_B_CAPTURE];
    assign capture_a = a_is_capture && (capture_compare_control_reg
        [`CCR_A_SRC_INV] ? edge_a_inverse : edge_b);
    // Only a pin edge captures; a counter read never does.
    assign capture_b = b_is_capture && edge_a; // [RULE9]

    // A match is taken on the step away from the compare value, so a
    // compare of zero fires on the 0000H to 0001H step after a wrap.
    assign match_a = count_tick && !a_is_capture &&
        main_counter16 == compare_reg_a; // [RULE12]
    assign match_b = count_tick && !b_is_capture &&
        main_counter16 == compare_reg_b; // [RULE12]
    assign overflow = count_tick && main_counter16 == COUNT_MAX; // [RULE19]

    assign start_on_b = compare_reg_b < compare_reg_a; // [RULE2]
    assign start_match = start_on_b ? match_b : match_a; // [RULE2]
    assign stop_match = start_on_b ? match_a : match_b; // [RULE2]

    assign clear_ovf = mode_wr && !reg_wdata[`MODE_OVF_BIT];

    always @(posedge sys_clk) begin
        if (reset) begin
            divider <= 7'h00;
        end else begin
            divider <= divider + 7'h01;
        end
    end

    // Configuration registers.  Software is expected to stop the timer
    // first; writes while running are taken as they come.
    always @(posedge sys_clk) begin
        if (reset) begin
            capture_compare_control_reg <= `CCR_RESET;
            prescaler_reg <= `PRE_RESET;
            output_control_reg <= `OUT_RESET;
        end else begin
            if (capture_ctrl_wr) begin
                capture_compare_control_reg <= reg_wdata; // [RULE22]
            end
            if (prescaler_wr) begin
                prescaler_reg <= reg_wdata; // [RULE22]
            end
            if (output_ctrl_wr) begin
                // Level set, level reset and trigger bits read as zero.
                output_control_reg <= reg_wdata &
                    `OUT_READ_MASK; // [RULE15] [RULE16]
            end
        end
    end

    // Mode register and overflow flag.  The hardware set wins over a
    // clear, and a clear just after the wrap is undone until 0001H.
    always @(posedge sys_clk) begin
        if (reset) begin
            mode_control_reg <= `MODE_RESET;
            just_overflowed <= 1'b0;
        end else begin
            if (mode_wr) begin
                mode_control_reg[7:1] <= reg_wdata[7:1]; // [RULE3] [RULE7]
            end
            if (overflow || just_overflowed) begin
                mode_control_reg[`MODE_OVF_BIT] <= 1'b1; // [RULE19] [RULE20]
            end else if (clear_ovf) begin
                mode_control_reg[`MODE_OVF_BIT] <= 1'b0;
            end
            if (overflow) begin
                just_overflowed <= 1'b1; // [RULE20]
            end else if (count_tick || restart || !running) begin
                just_overflowed <= 1'b0;
            end
        end
    end

    // Counter.  A restart clears it at once; otherwise it advances on the
    // count clock, clears on a compare a match in clear-on-match mode and otherwise wraps freely, so a compare below the count is only
    // reached after the wrap.  It holds its value while stopped.
    always @(posedge sys_clk) begin
        if (reset) begin
            main_counter16 <= COUNT_ZERO;
        end else if (restart) begin
            main_counter16 <= COUNT_ZERO; // [RULE1] [RULE5]
        end else if (count_tick) begin
            if (op_mode == `OP_CLEAR_MATCH &&
                main_counter16 == compare_reg_a) begin
                main_counter16 <= COUNT_ZERO; // [RULE19]
            end else begin
                main_counter16 <= main_counter16 + COUNT_ONE; // [RULE13]
            end
        end
    end

    // Capture/compare registers.  A capture takes priority over a write
    // or a read in the same cycle.  Nothing restores them on stop, so
    // their contents after stopping carry no meaning.
    always @(posedge sys_clk) begin
        if (reset) begin
            compare_reg_a <= COUNT_ZERO;
            compare_reg_b <= COUNT_ZERO;
        end else begin
            if (capture_a) begin
                compare_reg_a <= main_counter16; // [RULE21] [RULE14]
            end else if (compare_a_wr) begin
                compare_reg_a <= compare_wdata; // [RULE13]
            end
            if (capture_b) begin
                compare_reg_b <= main_counter16; // [RULE21] [RULE14]
            end else if (compare_b_wr) begin
                compare_reg_b <= compare_wdata; // [RULE13]
            end
        end
    end

    // Interrupt pulses: matches in compare mode, edges in capture mode.
    // Both stay quiet while stopped because no tick or edge exists then.
    always @(posedge sys_clk) begin
        if (reset) begin
            match_irq_a <= 1'b0;
            match_irq_b <= 1'b0;
        end else begin
            match_irq_a <= match_a || capture_a; // [RULE11] [RULE12]
            match_irq_b <= match_b || capture_b; // [RULE11] [RULE12]
        end
    end

    // One-shot pulse.  A restart arms it, the earlier compare drives the
    // output active and the later one ends it.  A trigger during a pulse
    // simply rearms; that case is outside the supported use.
    always @(posedge sys_clk) begin
        if (reset) begin
            pulse_armed <= 1'b0;
            pulse_level <= 1'b0;
            pulse_output_pin <= 1'b0;
        end else begin
            if (output_ctrl_wr && reg_wdata[`OUT_LEVEL_SET]) begin
                pulse_level <= 1'b1;
                pulse_output_pin <= output_control_reg[`OUT_ENABLE];
            end else if (output_ctrl_wr && reg_wdata[`OUT_LEVEL_RESET]) begin
                pulse_level <= 1'b0;
                pulse_output_pin <= 1'b0;
            end else if (restart && one_shot_mode) begin
                pulse_armed <= 1'b1; // [RULE1] [RULE4]
                pulse_level <= 1'b0;
                pulse_output_pin <= 1'b0;
            end else if (pulse_armed && one_shot_mode && start_match) begin
                pulse_level <= 1'b1; // [RULE1] [RULE2]
                pulse_output_pin <= output_control_reg[`OUT_ENABLE];
            end else if (pulse_armed && one_shot_mode && stop_match &&
                pulse_level) begin
                pulse_armed <= 1'b0; // [RULE1] [RULE3]
                pulse_level <= 1'b0;
                pulse_output_pin <= 1'b0;
            end else begin
                pulse_output_pin <= pulse_level &&
                    output_control_reg[`OUT_ENABLE];
            end
        end
    end

endmodule // timer16_one_shot_pulse

`default_nettype wire

// ### testbench/timer16_one_shot_pulse_chk.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_chk #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Software access.
    input wire logic mode_wr,
    input wire logic output_ctrl_wr,
    input wire logic compare_b_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic counter_read,
    // Pin and register contents.
    input wire logic pulse_output_pin,
    input wire logic [WIDTH-1:0] main_counter16,
    input wire logic [WIDTH-1:0] compare_reg_a,
    input wire logic [WIDTH-1:0] compare_reg_b,
    input wire logic [7:0] mode_control_reg,
    input wire logic [7:0] capture_compare_control_reg,
    input wire logic [7:0] output_control_reg,
    input wire logic [7:0] prescaler_reg,
    // Events.
    input wire logic match_irq_a,
    input wire logic match_irq_b
);
    wire [1:0] op = mode_control_reg[3:2];
    // Free run at full rate with no read, so every cycle is a count tick.
    wire run1 = prescaler_reg[1:0] == 2'h0 && op == 2'h2 && !counter_read;
    wire quiet = !mode_wr && !output_ctrl_wr;
    wire shot_on = output_control_reg[0] && output_control_reg[5];
    wire b_first = compare_reg_b < compare_reg_a;
    wire [WIDTH-1:0] on_val = b_first ? compare_reg_b : compare_reg_a;
    wire [WIDTH-1:0] off_val = b_first ? compare_reg_a : compare_reg_b;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence wrap_s;
        run1 && !output_ctrl_wr && main_counter16 == 16'hffff
            ##1 main_counter16 == 16'h0000;
    endsequence
    sequence soft_fire_s;
        output_ctrl_wr && reg_wdata[6:5] == 2'h3 && reg_wdata[3:2] == 2'h0
            && output_control_reg[5] && (op == 2'h1 || op == 2'h2) && !mode_wr;
    endsequence
    trig_clear_a: assert property (
        soft_fire_s |-> ##[1:2] main_counter16 == 16'h0000)
        else $error("trigger did not clear counter");
    ctrl_read_a: assert property (
        output_ctrl_wr |=> output_control_reg[6] == 1'b0
            && output_control_reg[3:2] == 2'h0) else $error("bits read 1");
    stop_hold_a: assert property (
        op == 2'h0 && !mode_wr |=> $stable(main_counter16)
            && !match_irq_a && !match_irq_b) else $error("stopped timer moved");
    read_pause_a: assert property (
        counter_read && op == 2'h2 && quiet |=> $stable(main_counter16))
        else $error("counter moved during read");
    read_nocap_a: assert property (
        counter_read && !compare_b_wr && !capture_compare_control_reg[2]
            |=> $stable(compare_reg_b)) else $error("read captured");
    ovf_set_a: assert property (
        run1 && quiet && main_counter16 == 16'hffff
            && compare_reg_a == 16'hffff |=> mode_control_reg[0]
            && main_counter16 == 16'h0000) else $error("overflow missed");
    ovf_keep_a: assert property (
        wrap_s ##0 (mode_wr && reg_wdata[3:2] == 2'h2)
            |=> mode_control_reg[0]) else $error("early clear took effect");
    irq_b_a: assert property (
        run1 && quiet && !capture_compare_control_reg[2]
            && main_counter16 == compare_reg_b |=> match_irq_b)
        else $error("match event b missing");
    pulse_off_a: assert property (
        run1 && quiet && shot_on && main_counter16 == off_val
            |=> !pulse_output_pin) else $error("pulse did not end");
    pulse_on_a: assert property (
        $rose(pulse_output_pin) && !$past(output_ctrl_wr) && shot_on
            |-> $past(main_counter16) == $past(on_val))
        else $error("pulse began off its match");
endmodule // timer16_chk
bind timer16_one_shot_pulse timer16_chk #(.WIDTH(WIDTH)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .mode_wr(mode_wr),
    .output_ctrl_wr(output_ctrl_wr), .compare_b_wr(compare_b_wr),
    .reg_wdata(reg_wdata), .counter_read(counter_read),
    .pulse_output_pin(pulse_output_pin), .main_counter16(main_counter16),
    .compare_reg_a(compare_reg_a), .compare_reg_b(compare_reg_b),
    .mode_control_reg(mode_control_reg),
    .capture_compare_control_reg(capture_compare_control_reg),
    .output_control_reg(output_control_reg),
    .prescaler_reg(prescaler_reg), .match_irq_a(match_irq_a),
    .match_irq_b(match_irq_b)
);
`default_nettype wire

// ### testbench/pulse_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_load_model (
    // Clock and bench command.
    input wire logic sys_clk,
    input wire logic fire,
    // Timer pins.
    input wire logic pulse,
    output logic trig_a,
    output logic trig_b,
    // Width of the last pulse in clocks, and pulses seen.
    output logic [15:0] width,
    output logic [7:0] seen
);
    logic [15:0] run;
    logic [3:0] hold;
    initial begin
        {trig_a, trig_b, width, seen, run, hold} = '0;
    end
    // The edge line rests low and moves only on command.
    always @(posedge sys_clk) begin
        if (fire && !pulse) begin // no new edge inside a pulse
            trig_a <= 1'b1;
            hold <= 4'hf;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end else begin
            trig_a <= 1'b0;
        end
        // Line b follows line a one clock late, for capture tests.
        trig_b <= trig_a;
        run <= pulse ? run + 16'h0001 : 16'h0000;
        if (!pulse && run != 16'h0000) begin
            width <= run;
            seen <= seen + 8'h01;
        end
    end
endmodule // pulse_load_model
`default_nettype wire

// ### testbench/timer16_one_shot_pulse_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_one_shot_pulse_bench;
    logic sys_clk, reset, counter_read, fire, pulse_output_pin;
    logic trigger_capture_input_a, trigger_capture_input_b;
    logic match_irq_a, match_irq_b;
    logic [5:0] st;
    logic [7:0] reg_wdata, mode_control_reg, capture_compare_control_reg;
    logic [7:0] output_control_reg, prescaler_reg, seen;
    logic [15:0] compare_wdata, main_counter16, compare_reg_a, compare_reg_b;
    logic [15:0] width, a, b, c;
    int err_count, checks, irqs_a, irqs_b, i, base;
    timer16_one_shot_pulse #(.WIDTH(16)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .mode_wr(st[0]),
        .capture_ctrl_wr(st[1]), .output_ctrl_wr(st[2]),
        .prescaler_wr(st[3]), .compare_a_wr(st[4]), .compare_b_wr(st[5]),
        .reg_wdata(reg_wdata), .compare_wdata(compare_wdata),
        .counter_read(counter_read),
        .trigger_capture_input_a(trigger_capture_input_a),
        .trigger_capture_input_b(trigger_capture_input_b),
        .pulse_output_pin(pulse_output_pin), .main_counter16(main_counter16),
        .compare_reg_a(compare_reg_a), .compare_reg_b(compare_reg_b),
        .mode_control_reg(mode_control_reg),
        .capture_compare_control_reg(capture_compare_control_reg),
        .output_control_reg(output_control_reg),
        .prescaler_reg(prescaler_reg), .match_irq_a(match_irq_a),
        .match_irq_b(match_irq_b));
    pulse_load_model i_load (.sys_clk(sys_clk), .fire(fire),
        .pulse(pulse_output_pin), .trig_a(trigger_capture_input_a),
        .trig_b(trigger_capture_input_b), .width(width), .seen(seen));
    function automatic [15:0] gap(input [15:0] x, input [15:0] y);
        gap = x > y ? x - y : y - x;
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A spare cycle before each strobe keeps two writes from sharing a step.
    task wr(input int w, input [15:0] d);
        cyc(1);
        st = 6'h01 << w;
        reg_wdata = d[7:0];
        compare_wdata = d;
        cyc(1);
        st = 6'h00;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Compares are rewritten every time, since a stop may lose them.
    task shot(input [15:0] x, input [15:0] y, input bit ext);
        int s;
        wr(0, 16'h0000); // stop before setup
        wr(3, 16'h0010);
        wr(1, 16'h0000);
        wr(2, 16'h0021);
        wr(4, x); // nonzero and unequal
        wr(5, y);
        wr(0, ext ? 16'h0004 : 16'h0008);
        s = seen;
        if (ext) begin
            fire = 1'b1; // external start
            cyc(1);
            fire = 1'b0;
        end else begin
            wr(2, 16'h0061); // only in one-shot setup
            chk(output_control_reg, 16'h0021);
        end
        for (i = 0; i < 400 && seen == s; i++) cyc(1);
        chk(width, gap(x, y));
        c = main_counter16;
        cyc(3);
        chk(main_counter16, c + 16'h0003);
        $display("test pulse done");
    endtask
    always @(posedge sys_clk) begin
        irqs_a <= irqs_a + match_irq_a;
        irqs_b <= irqs_b + match_irq_b;
    end
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #(20 * 100000);
        err_count++;
        conclude();
    end
    initial begin
        {reset, st, reg_wdata, compare_wdata, counter_read, fire} = '1;
        {st, reg_wdata, compare_wdata, counter_read, fire} = '0;
        {err_count, checks} = '0;
        void'($urandom(10));
        cyc(2);
        reset = 1'b0;
        chk(main_counter16 | compare_reg_a | compare_reg_b, 16'h0000);
        chk({mode_control_reg, output_control_reg}, 16'h0000);
        $display("test reset done");
        shot(16'h0002, 16'h0001, 1'b0);
        for (int n = 0; n < 6; n++) begin
            b = 16'(1 + $urandom % 60);
            a = b + 16'(1 + $urandom % 60);
            if (n % 2) shot(b, a, n > 2);
            else shot(a, b, n > 2);
        end
        wr(0, 16'h0000);
        cyc(2);
        c = main_counter16;
        base = irqs_a + irqs_b;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(30);
        chk(main_counter16, c);
        chk(16'(irqs_a + irqs_b - base), 16'h0000);
        wr(2, 16'h000d);
        chk(output_control_reg & 8'h4c, 16'h0000);
        $display("test stop done");
        wr(2, 16'h0000);
        wr(3, 16'h0000);
        wr(4, 16'hffff);
        wr(5, 16'h0000);
        wr(0, 16'h0008);
        counter_read = 1'b1;
        c = main_counter16;
        cyc(1 + $urandom % 8);
        chk(main_counter16, c);
        chk(compare_reg_b, 16'h0000);
        counter_read = 1'b0;
        $display("test read done");
        for (i = 0; i < 70000 && main_counter16 !== 16'hffff; i++) cyc(1);
        base = irqs_a;
        wr(0, 16'h0008);
        chk(mode_control_reg, 16'h0009);
        chk(match_irq_b, 16'h0001);
        chk(16'(irqs_a - base), 16'h0001);
        wr(0, 16'h0008);
        chk(mode_control_reg, 16'h0008);
        wr(5, 16'h0001);
        base = irqs_b;
        cyc(60);
        chk(16'(irqs_b - base), 16'h0000);
        $display("test overflow done");
        // Register a captures both edges of line b while a read holds
        // the counter, so each capture must take the frozen count.
        wr(0, 16'h0000);
        wr(1, 16'h0001);
        wr(3, 16'h00d0);
        wr(0, 16'h0008);
        counter_read = 1'b1;
        c = main_counter16;
        base = irqs_a;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(40);
        chk(compare_reg_a, c);
        chk(16'(irqs_a - base), 16'h0002);
        counter_read = 1'b0;
        $display("test capture done");
        conclude();
    end
endmodule // timer16_one_shot_pulse_bench
`default_nettype wire
